// *** design/oag_top.sv ***
// Operation
// RULE1 - immediate operand value is taken straight from the instruction
// RULE2 - word in register file uses named register and the next one
// RULE3 - register direct by absolute address or short working-register number
// RULE4 - register indirect: working register holds operand register address
// RULE5 - register indexed: working register plus one-byte immediate offset
// RULE6 - post-increment: pair and register pointers, move then both +1
// RULE7 - combined post-increment transfers allowed only for byte loads
// RULE8 - long-indexed memory destination with immediate only for word loads
// RULE9 - memory direct, indirect, inc, dec, short, long, register indexed
// RULE10 - direct bit selects any bit of any working register
// RULE11 - indirect bit selects a memory bit addressed by a register pair
// RULE12 - single-operand byte ops accept register direct or indirect only
// RULE13 - two-operand alu needs register direct side, with listed exceptions
// RULE14 - loads add register indexed and immediate to long indexed
// RULE15 - pre-decrement lowers the pair first, then accesses memory
// RULE16 - register-pair indexed address is sum of two even pairs
// RULE17 - memory accesses go to program or data space chosen earlier
// RULE18 - pointer updates wrap at 8 bits for registers, 16 for pairs
module oag_top (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rstn_i,
  // working-register window base
  input  wire logic [7:0]        wr_base_i,
  // space select instructions
  input  wire logic              set_prog_i,
  input  wire logic              set_data_i,
  // decoded request
  input  wire logic              req_valid_i,
  input  wire oag_pkg::oag_req_t req_i,
  // working register file read port (16 bytes of current window)
  input  wire logic [127:0]      wr_file_i,
  // results
  output logic                   res_valid_o,
  output logic                   illegal_o,
  output oag_pkg::oag_res_t      dst_o,
  output oag_pkg::oag_res_t      src_o,
  output oag_pkg::oag_wb_t       dst_wb_o,
  output oag_pkg::oag_wb_t       src_wb_o,
  output logic                   prog_space_o
);
  import oag_pkg::*;

  typedef struct packed {
    logic     valid;
    logic     illegal;
    logic     prog;
    oag_res_t dst;
    oag_res_t src;
    oag_wb_t  dwb;
    oag_wb_t  swb;
  } oag_state_t;

  oag_state_t st_r;
  oag_state_t st_nxt;
  logic [7:0] wr [16];

  ////////////////////////////////////////////////////////////////////////
  // working register window as bytes
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_wr
      assign wr[gi] = wr_file_i[gi*8 +: 8];
    end
  endgenerate

  function automatic logic [15:0] pair_val(input logic [3:0] n);
    logic [3:0] e;
    e = {n[3:1], 1'b0};
    return {wr[e], wr[e | 4'h1]};
  endfunction : pair_val

  function automatic logic is_mem(input oag_mode_t m);
    return m inside {OAG_M_MDIR, OAG_M_MIND, OAG_M_MPINC, OAG_M_MPDEC,
                     OAG_M_MSIDX, OAG_M_MLIDX, OAG_M_MRIDX, OAG_M_BITM};
  endfunction : is_mem

  function automatic logic is_midx(input oag_mode_t m);
    return m inside {OAG_M_MSIDX, OAG_M_MLIDX, OAG_M_MRIDX};
  endfunction : is_midx

  ////////////////////////////////////////////////////////////////////////
  // resolve one operand and its pointer write-back
  task automatic resolve(input oag_opnd_t o, input logic wd,
                         input logic prog, output oag_res_t r,
                         output oag_wb_t wb);
    logic [15:0] pv;
    logic [7:0]  ra;
    pv = pair_val(o.wr_num);
    ra = 8'h00;
    r  = '0;
    wb = '0;
    r.prog_space = prog;                                   // [RULE17]
    r.is_mem     = is_mem(o.mode);
    case (o.mode)
      OAG_M_IMM: begin
        r.is_imm = 1'b1;
        r.imm    = wd ? o.imm : {8'h00, o.imm[7:0]};      // [RULE1]
      end
      OAG_M_RDIR: begin
        ra = o.wr_short ? (wr_base_i | {4'h0, o.wr_num})
                        : o.reg_abs;                       // [RULE3]
      end
      OAG_M_RIND: ra = wr[o.wr_num];                       // [RULE4]
      OAG_M_RIDX: ra = wr[o.wr_num] + o.imm[7:0];          // [RULE5]
      OAG_M_RPINC: begin
        ra        = wr[o.wr_num];                          // [RULE6]
        wb.en     = 1'b1;
        wb.wr_num = o.wr_num;
        wb.value  = {8'h00, wr[o.wr_num] + 8'h01};         // [RULE18]
      end
      OAG_M_MDIR:  r.addr = o.imm;                         // [RULE9]
      OAG_M_MIND:  r.addr = pv;                            // [RULE9]
      OAG_M_MPINC: begin
        r.addr    = pv;                                    // [RULE6]
        wb.en     = 1'b1;
        wb.pair   = 1'b1;
        wb.wr_num = {o.wr_num[3:1], 1'b0};
        wb.value  = pv + OAG_PINC_STEP;                    // [RULE18]
      end
      OAG_M_MPDEC: begin
        r.addr    = pv - OAG_PINC_STEP;                    // [RULE15]
        wb.en     = 1'b1;
        wb.pair   = 1'b1;
        wb.wr_num = {o.wr_num[3:1], 1'b0};
        wb.value  = pv - OAG_PINC_STEP;                    // [RULE18]
      end
      OAG_M_MSIDX: r.addr = pv + {8'h00, o.imm[7:0]};      // [RULE9]
      OAG_M_MLIDX: r.addr = pv + o.imm;                    // [RULE9]
      OAG_M_MRIDX: r.addr = pv + pair_val(o.wr_num2);      // [RULE16]
      OAG_M_BITR: begin
        ra        = wr_base_i | {4'h0, o.wr_num};          // [RULE10]
        r.is_bit  = 1'b1;
        r.bit_idx = o.bit_idx;
      end
      OAG_M_BITM: begin
        r.addr    = pv;                                    // [RULE11]
        r.is_bit  = 1'b1;
        r.bit_idx = o.bit_idx;
      end
      default: r = '0;
    endcase
    if (!r.is_mem && !r.is_imm) begin
      r.addr    = {8'h00, ra};
      r.addr_hi = ra + 8'h01;                              // [RULE2]
    end
  endtask : resolve

  ////////////////////////////////////////////////////////////////////////
  // legality of the combination
  function automatic logic legal(input oag_req_t q);
    oag_mode_t d;
    oag_mode_t s;
    logic      alu_ok;
    logic      pinc;
    d = q.dst.mode;
    s = q.src.mode;
    // register direct on one side with a register direct or indirect, non-bit memory or immediate other side; an immediate only as source
    alu_ok = ((d == OAG_M_RDIR) &&
              (s inside {OAG_M_RDIR, OAG_M_RIND, OAG_M_MIND, OAG_M_MPINC,
                         OAG_M_MPDEC, OAG_M_MDIR, OAG_M_IMM}
               || is_midx(s)))
          || ((s == OAG_M_RDIR) &&
              (d inside {OAG_M_RIND, OAG_M_MIND, OAG_M_MPINC,
                         OAG_M_MPDEC, OAG_M_MDIR} || is_midx(d)))
          || ((s == OAG_M_IMM) && (d inside {OAG_M_MDIR, OAG_M_MIND}))
          || ((s == OAG_M_MDIR) && (d == OAG_M_MIND));      // [RULE13]
    pinc = ((d == OAG_M_RPINC) && (s == OAG_M_MPINC))
        || ((d == OAG_M_MPINC) && (s inside {OAG_M_RPINC, OAG_M_MPINC}));
    case (q.cls)
      OAG_C_ONE:  return !q.word && (d inside {OAG_M_RDIR, OAG_M_RIND})
                        && (s == OAG_M_NONE);              // [RULE12]
      OAG_C_ALU2: return alu_ok;                           // [RULE13]
      OAG_C_LOAD: return alu_ok
        || ((d == OAG_M_RDIR) && (s == OAG_M_RIDX))
        || ((s == OAG_M_RDIR) && (d == OAG_M_RIDX))        // [RULE14]
        || ((d == OAG_M_MLIDX) && (s == OAG_M_IMM) && q.word) // [RULE8]
        || (pinc && !q.word);                              // [RULE7]
      OAG_C_BIT:  return (d inside {OAG_M_BITR, OAG_M_BITM})
        && (s inside {OAG_M_NONE, OAG_M_BITR});            // [RULE10]
      default:    return 1'b0;
    endcase
  endfunction : legal

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    oag_res_t rd;
    oag_res_t rs;
    oag_wb_t  wd;
    oag_wb_t  ws;
    logic     ok;
    rd     = '0;
    rs     = '0;
    wd     = '0;
    ws     = '0;
    ok     = 1'b0;
    st_nxt = st_r;
    if (set_prog_i) begin
      st_nxt.prog = 1'b1;                                  // [RULE17]
    end else if (set_data_i) begin
      st_nxt.prog = 1'b0;
    end
    resolve(req_i.dst, req_i.word, st_r.prog, rd, wd);
    resolve(req_i.src, req_i.word, st_r.prog, rs, ws);
    ok             = legal(req_i);
    st_nxt.valid   = req_valid_i;
    st_nxt.illegal = req_valid_i && !ok;
    st_nxt.dst     = rd;
    st_nxt.src     = rs;
    // data moves on the resolved address; pointers update after
    st_nxt.dwb     = (req_valid_i && ok) ? wd : '0;        // [RULE6]
    st_nxt.swb     = (req_valid_i && ok) ? ws : '0;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r      <= '0;
      st_r.prog <= OAG_SPACE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign res_valid_o  = st_r.valid;
  assign illegal_o    = st_r.illegal;
  assign dst_o        = st_r.dst;
  assign src_o        = st_r.src;
  assign dst_wb_o     = st_r.dwb;
  assign src_wb_o     = st_r.swb;
  assign prog_space_o = st_r.prog;

endmodule : oag_top

// *** design/oag_pkg.sv ***
package oag_pkg;

  // addressing modes of one operand
  typedef enum logic [3:0] {
    OAG_M_IMM      = 4'h0,
    OAG_M_RDIR     = 4'h1,
    OAG_M_RIND     = 4'h2,
    OAG_M_RIDX     = 4'h3,
    OAG_M_RPINC    = 4'h4,
    OAG_M_MDIR     = 4'h5,
    OAG_M_MIND     = 4'h6,
    OAG_M_MPINC    = 4'h7,
    OAG_M_MPDEC    = 4'h8,
    OAG_M_MSIDX    = 4'h9,
    OAG_M_MLIDX    = 4'ha,
    OAG_M_MRIDX    = 4'hb,
    OAG_M_BITR     = 4'hc,
    OAG_M_BITM     = 4'hd,
    OAG_M_NONE     = 4'hf
  } oag_mode_t;

  // instruction classes that constrain mode combinations
  typedef enum logic [1:0] {
    OAG_C_ONE   = 2'h0,
    OAG_C_ALU2  = 2'h1,
    OAG_C_LOAD  = 2'h2,
    OAG_C_BIT   = 2'h3
  } oag_class_t;

  // one operand as carried in the decoded instruction
  typedef struct packed {
    oag_mode_t   mode;
    logic        wr_short;   // working-register number given
    logic [7:0]  reg_abs;    // absolute register-file address
    logic [3:0]  wr_num;     // working register / pair number
    logic [3:0]  wr_num2;    // second pair for register index
    logic [15:0] imm;        // immediate, offset or direct address
    logic [2:0]  bit_idx;
  } oag_opnd_t;

  typedef struct packed {
    oag_class_t  cls;
    logic        word;
    oag_opnd_t   dst;
    oag_opnd_t   src;
  } oag_req_t;

  // resolved operand
  typedef struct packed {
    logic        is_imm;
    logic        is_mem;
    logic        prog_space;
    logic [15:0] addr;       // register or memory address
    logic [7:0]  addr_hi;    // second register of a word pair
    logic [15:0] imm;
    logic [2:0]  bit_idx;
    logic        is_bit;
  } oag_res_t;

  // pointer update written back to working registers
  typedef struct packed {
    logic        en;
    logic        pair;
    logic [3:0]  wr_num;
    logic [15:0] value;
  } oag_wb_t;

  localparam logic [7:0]  OAG_WR_BASE_RST = 8'hd0;
  localparam logic [15:0] OAG_PINC_STEP   = 16'h0001;
  localparam logic        OAG_SPACE_RST   = 1'b0;

endpackage : oag_pkg

// *** tb/oag_props.sv ***
module oag_props import oag_pkg::*; (
  // watched ports
  input wire logic         core_clk_i,
  input wire logic         rstn_i,
  input wire logic         set_prog_i,
  input wire logic         req_valid_i,
  input wire logic [7:0]   wr_base_i,
  input wire logic [127:0] wr_file_i,
  input wire oag_req_t     req_i,
  input wire logic         illegal_o,
  input wire logic         prog_space_o,
  input wire oag_res_t     src_o,
  input wire oag_wb_t      src_wb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  oag_opnd_t   s;
  logic [7:0]  r1;
  logic [15:0] p1, p2;
  assign s  = req_i.src;
  assign r1 = wr_file_i[s.wr_num*8+:8];
  assign p1 = {wr_file_i[{s.wr_num[3:1], 1'b0}*8+:8],
               wr_file_i[{s.wr_num[3:1], 1'b1}*8+:8]};
  assign p2 = {wr_file_i[{s.wr_num2[3:1], 1'b0}*8+:8],
               wr_file_i[{s.wr_num2[3:1], 1'b1}*8+:8]};
  property p_imm; req_valid_i && s.mode == OAG_M_IMM && req_i.word
    |=> illegal_o || src_o.imm == $past(s.imm); endproperty
  a_imm: assert property (p_imm) else $error("imm wrong");
  property p_rind; req_valid_i && s.mode == OAG_M_RIND
    |=> illegal_o || src_o.addr[7:0] == $past(r1); endproperty
  a_rind: assert property (p_rind) else $error("rind wrong");
  property p_ridx; req_valid_i && s.mode == OAG_M_RIDX
    |=> illegal_o || src_o.addr[7:0] == $past(r1 + s.imm[7:0]); endproperty
  a_ridx: assert property (p_ridx) else $error("ridx wrong");
  property p_rdir; req_valid_i && s.mode == OAG_M_RDIR && s.wr_short
    |=> illegal_o || src_o.addr[7:0] == $past(wr_base_i | s.wr_num);
  endproperty
  a_rdir: assert property (p_rdir) else $error("rdir wrong");
  property p_pdec; req_valid_i && s.mode == OAG_M_MPDEC |=> illegal_o ||
    (src_o.addr == $past(p1 - 16'h1) && src_wb_o.value == src_o.addr);
  endproperty
  a_pdec: assert property (p_pdec) else $error("pdec wrong");
  property p_pinc; req_valid_i && s.mode == OAG_M_MPINC |=> illegal_o ||
    (src_wb_o.en && src_wb_o.value == $past(p1 + 16'h1)); endproperty
  a_pinc: assert property (p_pinc) else $error("pinc wrong");
  property p_mridx; req_valid_i && s.mode == OAG_M_MRIDX
    |=> illegal_o || src_o.addr == $past(p1 + p2); endproperty
  a_mridx: assert property (p_mridx) else $error("mridx wrong");
  property p_space; set_prog_i |=> prog_space_o; endproperty
  a_space: assert property (p_space) else $error("space wrong");
  property p_one; req_valid_i && req_i.cls == OAG_C_ONE &&
    !(req_i.dst.mode inside {OAG_M_RDIR, OAG_M_RIND}) |=> illegal_o;
  endproperty
  a_one: assert property (p_one) else $error("one-op wrong");
  property p_lidx; req_valid_i && req_i.dst.mode == OAG_M_MLIDX &&
    s.mode == OAG_M_IMM && !(req_i.cls == OAG_C_LOAD && req_i.word)
    |=> illegal_o; endproperty
  a_lidx: assert property (p_lidx) else $error("lidx wrong");
  c_pinc: cover property (req_valid_i && s.mode == OAG_M_MPINC);
  c_ill: cover property (illegal_o);
  c_prog: cover property (prog_space_o);
endmodule : oag_props
////////////////////////////////////////////////////////////////////////
bind oag_top oag_props i_oag_props (
  .core_clk_i   (core_clk_i),
  .rstn_i       (rstn_i),
  .set_prog_i   (set_prog_i),
  .req_valid_i  (req_valid_i),
  .wr_base_i    (wr_base_i),
  .wr_file_i    (wr_file_i),
  .req_i        (req_i),
  .illegal_o    (illegal_o),
  .prog_space_o (prog_space_o),
  .src_o        (src_o),
  .src_wb_o     (src_wb_o)
);

// *** tb/testbench.sv ***
module testbench import oag_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
    $display("ERROR %0t %h %h", $time, a, b); end end
  logic core_clk_i = 0, rstn_i = 0, set_prog_i = 0, set_data_i = 0;
  logic req_valid_i = 0, res_valid_o, illegal_o, prog_space_o;
  logic [7:0] wr_base_i = '0;
  logic [127:0] wr_file_i = '0;
  oag_req_t req_i = '0;
  oag_res_t dst_o, src_o;
  oag_wb_t dst_wb_o, src_wb_o;
  int fails = 0, tests_run = 0;
  logic [15:0] lf = 16'h005a;
  // one expected result per request, oldest first
  typedef struct packed {
    logic        il;
    logic        ps;
    logic [3:0]  bt;
    logic [7:0]  hi;
    logic [15:0] dx;
    logic [15:0] sx;
    logic [15:0] dw;
    logic [15:0] sw;
  } oag_exp_t;
  oag_exp_t q[$];
  oag_exp_t e;
  logic     sp = 1'b0;
  always #2.5 core_clk_i = ~core_clk_i;
  oag_top i_oag_top (
    .core_clk_i   (core_clk_i),
    .rstn_i       (rstn_i),
    .wr_base_i    (wr_base_i),
    .set_prog_i   (set_prog_i),
    .set_data_i   (set_data_i),
    .req_valid_i  (req_valid_i),
    .req_i        (req_i),
    .wr_file_i    (wr_file_i),
    .res_valid_o  (res_valid_o),
    .illegal_o    (illegal_o),
    .dst_o        (dst_o),
    .src_o        (src_o),
    .dst_wb_o     (dst_wb_o),
    .src_wb_o     (src_wb_o),
    .prog_space_o (prog_space_o)
  );
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction : rnd
  function automatic logic [15:0] pr(logic [3:0] n);
    return {wr_file_i[{n[3:1], 1'b0}*8+:8], wr_file_i[{n[3:1], 1'b1}*8+:8]};
  endfunction : pr
  // expected address or immediate of one operand
  function automatic logic [15:0] ex(oag_opnd_t o, logic w);
    logic [7:0] r;
    r = wr_file_i[o.wr_num*8+:8];
    case (o.mode)
      OAG_M_IMM:   return w ? o.imm : {8'h00, o.imm[7:0]};
      OAG_M_RIND:  return {8'h00, r};
      OAG_M_RPINC: return {8'h00, r};
      OAG_M_RIDX:  return {8'h00, 8'(r + o.imm[7:0])};
      OAG_M_RDIR:  return {8'h00, o.wr_short ?
                           (wr_base_i | {4'h0, o.wr_num}) : o.reg_abs};
      OAG_M_BITR:  return {8'h00, wr_base_i | {4'h0, o.wr_num}};
      OAG_M_MPDEC: return pr(o.wr_num) - 16'h0001;
      OAG_M_MSIDX: return pr(o.wr_num) + {8'h00, o.imm[7:0]};
      OAG_M_MLIDX: return pr(o.wr_num) + o.imm;
      OAG_M_MRIDX: return pr(o.wr_num) + pr(o.wr_num2);
      OAG_M_MDIR:  return o.imm;
      OAG_M_NONE:  return 16'h0000;
      default:     return pr(o.wr_num);
    endcase
  endfunction : ex
  // expected pointer write-back of one operand
  function automatic logic [15:0] wbx(oag_opnd_t o);
    case (o.mode)
      OAG_M_RPINC: return {8'h00, 8'(wr_file_i[o.wr_num*8+:8] + 8'h01)};
      OAG_M_MPINC: return pr(o.wr_num) + 16'h0001;
      OAG_M_MPDEC: return pr(o.wr_num) - 16'h0001;
      default:     return 16'h0000;
    endcase
  endfunction : wbx
  // requests go back to back; valid is held between calls
  task automatic go(oag_class_t c, logic w, oag_mode_t dm, sm, logic il);
    oag_opnd_t d;
    oag_opnd_t s;
    oag_exp_t  x;
    @(negedge core_clk_i);
    wr_file_i = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    wr_base_i = 8'(rnd());
    s = 40'({rnd(), rnd(), rnd()});
    s.mode = sm;
    s.wr_short = 1'b1;
    d = 40'({rnd(), rnd(), rnd()});
    d.mode = dm;
    // whole request in one assignment, no glitch on the bus
    req_i = {c, w, d, s};
    x.il = il;
    x.ps = sp;
    x.bt = (dm inside {OAG_M_BITR, OAG_M_BITM}) ? {1'b1, d.bit_idx} : 4'h0;
    x.dx = ex(d, w);
    x.sx = ex(s, w);
    x.hi = (dm inside {OAG_M_RDIR, OAG_M_RIND, OAG_M_RIDX, OAG_M_RPINC,
                       OAG_M_BITR}) ? 8'(x.dx[7:0] + 8'h01) : 8'h00;
    x.dw = il ? 16'h0000 : wbx(d);
    x.sw = il ? 16'h0000 : wbx(s);
    q.push_back(x);
    req_valid_i = 1'b1;
  endtask : go
  task automatic test_done();
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////
  always @(negedge core_clk_i) begin
    if (res_valid_o === 1'b1) begin
      e = q.pop_front();
      `CHK(illegal_o, e.il)
      `CHK(dst_wb_o.value, e.dw)
      `CHK(src_wb_o.value, e.sw)
      if (!e.il) begin
        `CHK(dst_o.addr, e.dx)
        `CHK(src_o.is_imm ? src_o.imm : src_o.addr, e.sx)
        `CHK(dst_o.addr_hi, e.hi)
        `CHK({dst_o.is_bit, dst_o.bit_idx}, e.bt)
        `CHK(dst_o.prog_space, e.ps)
      end
    end
  end
  initial begin
    #50000;
    fails++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge core_clk_i);
    @(negedge core_clk_i) rstn_i = 1'b1;
    go(OAG_C_ALU2, 1'b1, OAG_M_RDIR, OAG_M_IMM, 1'b0);
    go(OAG_C_ALU2, 1'b0, OAG_M_RDIR, OAG_M_IMM, 1'b0);
    go(OAG_C_ALU2, 1'b0, OAG_M_RDIR, OAG_M_RIND, 1'b0);
    go(OAG_C_LOAD, 1'b0, OAG_M_RDIR, OAG_M_RIDX, 1'b0);
    go(OAG_C_ALU2, 1'b0, OAG_M_RIND, OAG_M_RDIR, 1'b0);
    go(OAG_C_LOAD, 1'b0, OAG_M_RDIR, OAG_M_MPINC, 1'b0);
    go(OAG_C_ALU2, 1'b1, OAG_M_RDIR, OAG_M_MPDEC, 1'b0);
    go(OAG_C_ALU2, 1'b0, OAG_M_RDIR, OAG_M_MRIDX, 1'b0);
    go(OAG_C_LOAD, 1'b1, OAG_M_RDIR, OAG_M_MLIDX, 1'b0);
    go(OAG_C_ALU2, 1'b0, OAG_M_MSIDX, OAG_M_RDIR, 1'b0);
    go(OAG_C_ALU2, 1'b0, OAG_M_MIND, OAG_M_MDIR, 1'b0);
    go(OAG_C_ALU2, 1'b0, OAG_M_RIND, OAG_M_RIND, 1'b1);
    go(OAG_C_ONE, 1'b0, OAG_M_MDIR, OAG_M_NONE, 1'b1);
    go(OAG_C_ONE, 1'b0, OAG_M_RDIR, OAG_M_NONE, 1'b0);
    go(OAG_C_LOAD, 1'b0, OAG_M_MLIDX, OAG_M_IMM, 1'b1);
    go(OAG_C_LOAD, 1'b1, OAG_M_MLIDX, OAG_M_IMM, 1'b0);
    go(OAG_C_LOAD, 1'b1, OAG_M_RPINC, OAG_M_MPINC, 1'b1);
    go(OAG_C_LOAD, 1'b0, OAG_M_RPINC, OAG_M_MPINC, 1'b0);
    go(OAG_C_ALU2, 1'b0, OAG_M_RIDX, OAG_M_RDIR, 1'b1);
    go(OAG_C_LOAD, 1'b0, OAG_M_RIDX, OAG_M_RDIR, 1'b0);
    go(OAG_C_BIT, 1'b0, OAG_M_BITR, OAG_M_BITR, 1'b0);
    go(OAG_C_BIT, 1'b0, OAG_M_BITM, OAG_M_NONE, 1'b0);
    @(negedge core_clk_i) req_valid_i = 1'b0;
    set_prog_i = 1'b1;
    @(negedge core_clk_i) set_prog_i = 1'b0;
    @(negedge core_clk_i) `CHK(prog_space_o, 1'b1)
    sp = 1'b1;
    go(OAG_C_LOAD, 1'b0, OAG_M_MIND, OAG_M_RDIR, 1'b0);
    @(negedge core_clk_i) req_valid_i = 1'b0;
    set_data_i = 1'b1;
    @(negedge core_clk_i) set_data_i = 1'b0;
    @(negedge core_clk_i) `CHK(prog_space_o, 1'b0)
    `CHK(q.size(), 0)
    test_done();
  end
endmodule : testbench
